/* File: verilog/txseq_top.sv */
// mode sequencer of a small FSK/OOK transmitter: preset pick, wake, idle sleep,
// forced transmit, channel hop and carrier/deviation arithmetic
// assumes control and data pins asynchronous to clk and a single-cycle register port
//
// Summary of operation
// - automatic mode: a rising data edge starts the wake sequence
// - in transmit state, after the wake time, every data level outside a serial access goes to the modulator; none during a frequency change
// - automatic mode: sleep after 2 ms or 20 ms of data inactivity
// - application write with mode bit 15 set wakes and transmits
// - forced transmit lasts until a write clears bit 15; no idle timeout
// - advanced operation starts only with data low at a control rising edge
// - after the startup delay the control level is sampled once
// - low selects FSK 868.3 MHz preset, high selects OOK 433.92 MHz preset
// - frequency change: ramp amplifier down, relock, ramp it back up
// - modulator input blocked while a serial access runs
// - carrier is frequency word times step; deviation is bits 12..5 times step
// - step is crystal over 2^14 in band 0, over 2^13 in band 1
// - a control rising edge opens a 24-edge configuration frame
// - application bit 3 picks 2 ms when zero, 20 ms when one
//
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
module txseq_top
    import txseq_pkg::*;
#(
    parameter int T_START_CYCLES = T_START_CYC,
    parameter int WAKE_CYCLES = WAKE_TO_TX_CYC,
    parameter int IDLE_SHORT_CYCLES = IDLE_SHORT_CYC,
    parameter int IDLE_LONG_CYCLES = IDLE_LONG_CYC,
    parameter int HOP0_CYCLES = HOP_SETTLE0_CYC,
    parameter int HOP1_CYCLES = HOP_SETTLE1_CYC
) (
    input logic clk,
    input logic rst,
    input logic ctrl_pin,
    input logic data_pin,
    input logic [4:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic mod_data,
    output logic pa_on,
    output logic synth_relock,
    output logic awake,
    output logic ook_sel,
    output logic pout_high,
    output logic advanced,
    output logic [31:0] carrier_hz,
    output logic [31:0] deviation_hz
);
    // ****************************************
    // pins and serial frames
    // ****************************************
    txseq_pin_if pins ();
    logic busy;
    logic app_wr;
    logic freq_wr;
    logic [18:0] frame_word;
    txseq_state_type state_r;
    txseq_state_type state_nxt;

    txseq_pin_sync u_sync (
        .clk(clk),
        .rst(rst),
        .ctrl_pin(ctrl_pin),
        .data_pin(data_pin),
        .pins(pins)
    );

    txseq_frame_rx u_rx (
        .clk(clk),
        .rst(rst),
        .enable(state_r != ST_BOOT),
        .pins(pins),
        .busy(busy),
        .app_wr(app_wr),
        .freq_wr(freq_wr),
        .word(frame_word)
    );

    function automatic logic [3:0] step_shift(input logic band);
        step_shift = band ? 4'(STEP_SHIFT_B1) : 4'(STEP_SHIFT_B0);
    endfunction

    // ****************************************
    // configuration words
    // ****************************************
    logic [15:0] app_r;
    logic [18:0] freq_r;
    logic [24:0] xtal_r;
    logic preset_high_r;
    logic advanced_r;
    logic [21:0] tmr_r;
    logic boot_done;
    logic [15:0] preset_app;
    logic [18:0] preset_freq;

    assign boot_done = state_r == ST_BOOT && tmr_r == 22'(T_START_CYCLES - 1);
    assign preset_app = pins.ctrl_lvl ? PRESET2_APP : PRESET1_APP;
    assign preset_freq = pins.ctrl_lvl ? PRESET2_FREQ : PRESET1_FREQ;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            app_r <= 16'h0;
            freq_r <= 19'h0;
            preset_high_r <= 1'b0;
        end else if (boot_done) begin
            // control level is taken once, at the end of the startup delay
            app_r <= preset_app;
            freq_r <= preset_freq;
            preset_high_r <= pins.ctrl_lvl;
        end else begin
            if (app_wr) begin
                app_r <= frame_word[15:0];
            end
            if (freq_wr) begin
                freq_r <= frame_word;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            advanced_r <= 1'b0;
        end else if (busy) begin
            advanced_r <= 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xtal_r <= XTAL_DEFAULT_HZ;
        end else if (reg_wr && reg_addr == REG_XTAL) begin
            xtal_r <= reg_wdata[24:0];
        end
    end

    // ****************************************
    // sequencer
    // ****************************************
    logic [21:0] idle_cnt_r;
    logic [21:0] idle_lim;
    logic [21:0] hop_lim;
    logic forced;
    logic forced_exit;

    assign forced = app_r[APP_MODE_BIT];
    assign idle_lim = app_r[APP_IDLE_BIT] ? 22'(IDLE_LONG_CYCLES - 1) : 22'(IDLE_SHORT_CYCLES - 1);
    assign hop_lim = app_r[APP_BAND_BIT] ? 22'(HOP1_CYCLES - 1) : 22'(HOP0_CYCLES - 1);
    assign forced_exit = app_wr && forced && !frame_word[APP_MODE_BIT];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_BOOT: begin
                if (boot_done) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (forced) begin
                    state_nxt = ST_WAKE;
                end else if (pins.data_rise && !busy) begin
                    state_nxt = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // the data pin is not watched here; holding it high is the host's part
                if (tmr_r == 22'(WAKE_CYCLES - 1)) begin
                    state_nxt = ST_TX;
                end
            end
            ST_TX: begin
                if (forced_exit) begin
                    state_nxt = ST_SLEEP;
                end else if (freq_wr) begin
                    state_nxt = ST_RAMP_DN;
                end else if (!forced && idle_cnt_r == idle_lim) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_RAMP_DN: begin
                if (tmr_r == 22'(RAMP_CYC - 1)) begin
                    state_nxt = ST_LOCK;
                end
            end
            ST_LOCK: begin
                if (tmr_r == hop_lim) begin
                    state_nxt = ST_RAMP_UP;
                end
            end
            ST_RAMP_UP: begin
                if (tmr_r == 22'(RAMP_CYC - 1)) begin
                    state_nxt = ST_TX;
                end
            end
            default: begin
                state_nxt = ST_BOOT;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_BOOT;
            tmr_r <= 22'h0;
        end else begin
            state_r <= state_nxt;
            tmr_r <= (state_nxt != state_r) ? 22'h0 : tmr_r + 22'h1;
        end
    end

    // any data edge restarts the inactivity count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            idle_cnt_r <= 22'h0;
        end else if (state_r != ST_TX || pins.data_edge) begin
            idle_cnt_r <= 22'h0;
        end else if (idle_cnt_r != idle_lim) begin
            idle_cnt_r <= idle_cnt_r + 22'h1;
        end
    end

    // ****************************************
    // radio-side outputs
    // ****************************************
    logic mod_data_r;
    logic pa_on_r;
    logic relock_r;
    logic awake_r;
    logic [31:0] carrier_r;
    logic [31:0] dev_r;
    logic [43:0] carrier_prod;
    logic [32:0] dev_prod;
    logic [31:0] carrier_calc;
    logic [31:0] dev_calc;

    assign carrier_prod = 44'(freq_r) * 44'(xtal_r);
    assign dev_prod = 33'(app_r[APP_FDEV_HI:APP_FDEV_LO]) * 33'(xtal_r);
    assign carrier_calc = 32'(carrier_prod >> step_shift(app_r[APP_BAND_BIT]));
    assign dev_calc = 32'(dev_prod >> step_shift(app_r[APP_BAND_BIT]));

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mod_data_r <= 1'b0;
            pa_on_r <= 1'b0;
            relock_r <= 1'b0;
            awake_r <= 1'b0;
        end else begin
            // a serial access would otherwise be sent over the air
            mod_data_r <= state_r == ST_TX && !busy && pins.data_lvl;
            pa_on_r <= state_nxt == ST_TX;
            relock_r <= state_nxt == ST_LOCK;
            awake_r <= state_nxt != ST_BOOT && state_nxt != ST_SLEEP;
        end
    end

    // arithmetic is registered so the wide products stay off the output pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            carrier_r <= 32'h0;
            dev_r <= 32'h0;
        end else begin
            carrier_r <= carrier_calc;
            dev_r <= dev_calc;
        end
    end

    // ****************************************
    // register port
    // ****************************************
    logic [31:0] rdata_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_XTAL: rdata_r <= {7'h0, xtal_r};
                REG_STATUS: rdata_r <= {22'h0, advanced_r, preset_high_r, busy, 7'(state_r)};
                REG_APP: rdata_r <= {16'h0, app_r};
                REG_FREQ: rdata_r <= {13'h0, freq_r};
                REG_CARRIER: rdata_r <= carrier_r;
                REG_DEV: rdata_r <= dev_r;
                default: rdata_r <= 32'h0;
            endcase
        end else begin
            rdata_r <= 32'h0;
        end
    end

    assign reg_rdata = rdata_r;
    assign mod_data = mod_data_r;
    assign pa_on = pa_on_r;
    assign synth_relock = relock_r;
    assign awake = awake_r;
    assign ook_sel = app_r[APP_MODUL_BIT];
    assign pout_high = app_r[APP_POUT_BIT];
    assign advanced = advanced_r;
    assign carrier_hz = carrier_r;
    assign deviation_hz = dev_r;

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_wake_on_rise: assert property (state_r == ST_SLEEP && pins.data_rise && !busy |=> state_r == ST_WAKE)
        else $error("data rising edge in sleep did not start wake");
    chk_tx_passes_data: assert property (state_r == ST_TX && !busy && pins.data_lvl |=> mod_data_r)
        else $error("data level not passed to modulator in transmit");
    chk_idle_sleep: assert property (state_r == ST_TX && !forced && !app_wr && !freq_wr
        && idle_cnt_r == idle_lim |=> state_r == ST_SLEEP)
        else $error("idle timeout did not return to sleep");
    chk_forced_wake: assert property (state_r == ST_SLEEP && forced |=> state_r == ST_WAKE)
        else $error("forced mode bit did not wake the device");
    chk_forced_hold: assert property (state_r == ST_TX && forced && !app_wr && !freq_wr |=> state_r == ST_TX)
        else $error("forced transmit left without a clearing write");
    chk_preset_pick: assert property (boot_done |=> app_r == $past(preset_app) && freq_r == $past(preset_freq))
        else $error("preset not taken from control level at startup end");
    chk_hop_start: assert property (state_r == ST_TX && freq_wr && !forced_exit |=> state_r == ST_RAMP_DN ##1 pa_on_r == 1'b0)
        else $error("frequency change did not ramp the amplifier down");
    chk_hop_order: assert property ($fell(state_r == ST_LOCK) |-> state_r == ST_RAMP_UP && !relock_r)
        else $error("relock not followed by ramp up");
    chk_busy_blocks: assert property (busy |=> !mod_data_r)
        else $error("modulator fed during serial access");
    chk_carrier_math: assert property (##1 carrier_r == $past(carrier_calc) && dev_r == $past(dev_calc))
        else $error("carrier or deviation not updated from the words");
endmodule

/* File: verilog/txseq_pkg.sv */
// constants, field layout and state codes for the transmitter mode sequencer
// assumes a single 125 MHz clock; every time below is turned into cycles here
package txseq_pkg;

    // ****************************************
    // clock and timing
    // ****************************************
    localparam int CLK_HZ = 125_000_000;
    localparam int US_CYC = CLK_HZ / 1_000_000;
    localparam int T_START_US = 200;
    localparam int T_START_CYC = T_START_US * US_CYC;
    localparam int WAKE_TO_TX_US = 2000;
    localparam int WAKE_TO_TX_CYC = WAKE_TO_TX_US * US_CYC;
    localparam int IDLE_SHORT_MS = 2;
    localparam int IDLE_SHORT_CYC = IDLE_SHORT_MS * 1000 * US_CYC;
    localparam int IDLE_LONG_MS = 20;
    localparam int IDLE_LONG_CYC = IDLE_LONG_MS * 1000 * US_CYC;
    localparam int RAMP_US = 20;
    localparam int RAMP_CYC = RAMP_US * US_CYC;
    localparam int HOP_SETTLE0_US = 500;
    localparam int HOP_SETTLE0_CYC = HOP_SETTLE0_US * US_CYC;
    localparam int HOP_SETTLE1_US = 400;
    localparam int HOP_SETTLE1_CYC = HOP_SETTLE1_US * US_CYC;

    // ****************************************
    // application word fields
    // ****************************************
    localparam int APP_MODE_BIT = 15;
    localparam int APP_MODUL_BIT = 14;
    localparam int APP_BAND_BIT = 13;
    localparam int APP_FDEV_HI = 12;
    localparam int APP_FDEV_LO = 5;
    localparam int APP_POUT_BIT = 4;
    localparam int APP_IDLE_BIT = 3;
    localparam int STEP_SHIFT_B0 = 14;
    localparam int STEP_SHIFT_B1 = 13;

    // ****************************************
    // serial frame layout
    // ****************************************
    localparam int FRAME_BITS = 24;
    localparam logic [2:0] OP_WR_APP = 3'h0;
    localparam logic [3:0] GUARD_WR_APP = 4'h0;
    localparam logic [2:0] OP_WR_FREQ = 3'h1;

    // ****************************************
    // presets, valid with a 26 MHz crystal
    // ****************************************
    localparam logic [24:0] XTAL_DEFAULT_HZ = 25'h18cba80;
    localparam longint PRESET1_HZ = 868_300_000;
    localparam longint PRESET2_HZ = 433_920_000;
    localparam logic [15:0] PRESET1_APP = 16'h20d0;
    localparam logic [15:0] PRESET2_APP = 16'h4018;
    localparam logic [18:0] PRESET1_FREQ = 19'((PRESET1_HZ << STEP_SHIFT_B1) / longint'(XTAL_DEFAULT_HZ));
    localparam logic [18:0] PRESET2_FREQ = 19'((PRESET2_HZ << STEP_SHIFT_B0) / longint'(XTAL_DEFAULT_HZ));

    // ****************************************
    // register port offsets
    // ****************************************
    localparam logic [4:0] REG_XTAL = 5'h00;
    localparam logic [4:0] REG_STATUS = 5'h04;
    localparam logic [4:0] REG_APP = 5'h08;
    localparam logic [4:0] REG_FREQ = 5'h0c;
    localparam logic [4:0] REG_CARRIER = 5'h10;
    localparam logic [4:0] REG_DEV = 5'h14;

    typedef enum logic [6:0] {
        ST_BOOT = 7'h01,
        ST_SLEEP = 7'h02,
        ST_WAKE = 7'h04,
        ST_TX = 7'h08,
        ST_RAMP_DN = 7'h10,
        ST_LOCK = 7'h20,
        ST_RAMP_UP = 7'h40
    } txseq_state_type;

endpackage

/* File: verilog/txseq_pin_if.sv */
// synchronised pin levels and their edges, shared inside the sequencer
// assumes one clock domain; the producer is txseq_pin_sync
`timescale 1ns/10ps
interface txseq_pin_if;
    logic ctrl_lvl;
    logic ctrl_rise;
    logic data_lvl;
    logic data_rise;
    logic data_edge;
    modport src (output ctrl_lvl, ctrl_rise, data_lvl, data_rise, data_edge);
    modport snk (input ctrl_lvl, ctrl_rise, data_lvl, data_rise, data_edge);
endinterface

/* File: verilog/txseq_pin_sync.sv */
// two-flop synchronisers and edge detectors for the control and data pins
// assumes both pins are asynchronous to clk and slower than clk/2
`timescale 1ns/10ps
module txseq_pin_sync (
    input logic clk,
    input logic rst,
    input logic ctrl_pin,
    input logic data_pin,
    txseq_pin_if.src pins
);
    logic [1:0] raw;
    logic [1:0] meta_r;
    logic [1:0] sync_r;
    logic [1:0] prev_r;

    assign raw = {data_pin, ctrl_pin};

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_pin
            // edges come from the second stage only, the first is left alone
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    meta_r[g] <= 1'b0;
                    sync_r[g] <= 1'b0;
                    prev_r[g] <= 1'b0;
                end else begin
                    meta_r[g] <= raw[g];
                    sync_r[g] <= meta_r[g];
                    prev_r[g] <= sync_r[g];
                end
            end
        end
    endgenerate

    assign pins.ctrl_lvl = sync_r[0];
    assign pins.ctrl_rise = sync_r[0] & ~prev_r[0];
    assign pins.data_lvl = sync_r[1];
    assign pins.data_rise = sync_r[1] & ~prev_r[1];
    assign pins.data_edge = sync_r[1] ^ prev_r[1];
endmodule

/* File: verilog/txseq_frame_rx.sv */
// 24-bit configuration frame receiver clocked by control-pin rising edges
// assumes synchronised pins; reads and the recovery pattern are dropped
`timescale 1ns/10ps
module txseq_frame_rx
    import txseq_pkg::*;
(
    input logic clk,
    input logic rst,
    input logic enable,
    txseq_pin_if.snk pins,
    output logic busy,
    output logic app_wr,
    output logic freq_wr,
    output logic [18:0] word
);
    logic [22:0] sh_r;
    logic [4:0] cnt_r;
    logic busy_r;
    logic app_wr_r;
    logic freq_wr_r;
    logic [23:0] full;
    logic start_ok;

    assign full = {sh_r, pins.data_lvl};
    // a frame only opens with the data pin low at the control edge
    assign start_ok = enable && !busy_r && pins.ctrl_rise && !pins.data_lvl;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sh_r <= 23'h0;
            cnt_r <= 5'h0;
            busy_r <= 1'b0;
            app_wr_r <= 1'b0;
            freq_wr_r <= 1'b0;
        end else begin
            app_wr_r <= 1'b0;
            freq_wr_r <= 1'b0;
            if (start_ok) begin
                busy_r <= 1'b1;
                cnt_r <= 5'h1;
                sh_r <= 23'h0;
            end else if (busy_r && pins.ctrl_rise) begin
                sh_r <= full[22:0];
                cnt_r <= cnt_r + 5'h1;
                // a partial frame keeps the port busy; the host owes every edge
                if (cnt_r == 5'(FRAME_BITS - 1)) begin
                    busy_r <= 1'b0;
                    app_wr_r <= full[22:20] == OP_WR_APP && full[19:16] == GUARD_WR_APP;
                    freq_wr_r <= full[22:20] == OP_WR_FREQ && full[19];
                end
            end
        end
    end

    assign busy = busy_r;
    assign app_wr = app_wr_r;
    assign freq_wr = freq_wr_r;
    assign word = sh_r[18:0];

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    chk_frame_open: assert property ($rose(busy_r) |-> $past(start_ok))
        else $error("frame opened without a low data pin at the control edge");
    chk_frame_close: assert property ($fell(busy_r) |-> $past(cnt_r) == 5'd23)
        else $error("frame closed before its last bit");
endmodule

/* File: tb/txseq_host_model.sv */
// host microcontroller model driving the control and data pins of the sequencer
// assumes the bench calls its tasks; frames use an 80 ns control period
`timescale 1ns/10ps
module txseq_host_model (
    output logic ctrl_pin,
    output logic data_pin
);
    // push-pull outputs driven from time zero so the boot sample sees a real level
    initial begin
        ctrl_pin = 1'b0;
        data_pin = 1'b0;
    end

    task automatic drive(input logic c, input logic d);
        ctrl_pin = c;
        data_pin = d;
    endtask

    // data changes at the falling control edge; control stands still outside frames
    task automatic send_frame(input logic [23:0] w);
        #20;
        for (int i = 23; i >= 0; i--) begin
            data_pin = w[i];
            #40 ctrl_pin = 1'b1;
            #40 ctrl_pin = 1'b0;
        end
        #40 data_pin = 1'b0;
    endtask

    task automatic pulse_ctrl;
        #40 ctrl_pin = 1'b1;
        #40 ctrl_pin = 1'b0;
    endtask
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the transmitter mode sequencer, short timing parameters
// assumes the host model owns both pins; the register port is driven here
`timescale 1ns/10ps
module testbench;
    import txseq_pkg::*;
    logic clk, rst, reg_wr, reg_rd, mod_data, pa_on, synth_relock, awake, ook_sel, pout_high, advanced;
    logic ctrl_pin, data_pin, blocked_ok;
    logic [4:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, carrier_hz, deviation_hz, rd;
    int fail_count = 0;
    int samples_checked = 0;
    typedef struct {logic boot; logic [15:0] app; logic [18:0] freq; logic ook;} txseq_row_type;
    // preset 1 runs last so the later cases start from the short idle timeout
    txseq_row_type rows [2] = '{'{1'b1, PRESET2_APP, PRESET2_FREQ, 1'b1},
                                '{1'b0, PRESET1_APP, PRESET1_FREQ, 1'b0}};

    // startup and band-0 hop keep their real lengths; only the long waits are shortened
    txseq_top #(.WAKE_CYCLES(30), .IDLE_SHORT_CYCLES(40), .IDLE_LONG_CYCLES(90),
        .HOP1_CYCLES(20)) txseq_top_i (.clk, .rst, .ctrl_pin, .data_pin, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mod_data, .pa_on, .synth_relock, .awake, .ook_sel,
        .pout_high, .advanced, .carrier_hz, .deviation_hz);
    txseq_host_model txseq_host_model_i (.ctrl_pin, .data_pin);

    // ****************************************
    // helpers
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic reg_write(input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [4:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask

    function automatic logic [31:0] scaled(input logic [18:0] w, input logic [31:0] x, input logic b);
        return 32'((longint'(w) * longint'(x)) >> (b ? STEP_SHIFT_B1 : STEP_SHIFT_B0));
    endfunction

    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (2 * T_START_CYC + 20000) @(posedge clk);
        fail_count++;
        end_of_test;
    end

    // ****************************************
    // tests
    // ****************************************
    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 32'h0;
        blocked_ok = 1'b1;
        foreach (rows[i]) begin
            // pin set after time zero so the host model's start value cannot race it
            @(posedge clk);
            txseq_host_model_i.drive(rows[i].boot, 1'b0);
            rst <= 1'b1;
            repeat (20) @(posedge clk);
            rst <= 1'b0;
            tick(T_START_CYC + 20);
            reg_read(REG_APP);
            check("app", rd, {16'h0, rows[i].app});
            reg_read(REG_FREQ);
            check("freq", rd, {13'h0, rows[i].freq});
            check("ook", ook_sel, rows[i].ook);
            check("carrier", carrier_hz, scaled(rows[i].freq, 26000000, rows[i].app[13]));
            check("deviation", deviation_hz, scaled(rows[i].app[12:5], 26000000, rows[i].app[13]));
            $display("preset row %0d done", i);
        end
        txseq_host_model_i.drive(1'b0, 1'b1);
        tick(10);
        check("awake", awake, 1'b1);
        check("pa early", pa_on, 1'b0);
        tick(50);
        check("pa", pa_on, 1'b1);
        check("mod high", mod_data, 1'b1);
        txseq_host_model_i.drive(1'b0, 1'b0);
        tick(20);
        check("mod low", mod_data, 1'b0);
        check("pa held", pa_on, 1'b1);
        tick(40);
        check("asleep", awake, 1'b0);
        txseq_host_model_i.drive(1'b0, 1'b1);
        // data high with a control edge, kept far below the recovery high limit
        txseq_host_model_i.pulse_ctrl;
        tick(10);
        check("no frame", advanced, 1'b0);
        // this rise also woke the device, so data stays high through the wake time
        tick(20);
        txseq_host_model_i.drive(1'b0, 1'b0);
        tick(130);
        $display("automatic wake done");
        // long pause so the idle timeout puts the device back to sleep before the first frame
        txseq_host_model_i.send_frame(24'h00a0d8);
        tick(5);
        check("advanced", advanced, 1'b1);
        repeat (100) if (pa_on !== 1'b1) tick(1);
        check("forced tx", pa_on, 1'b1);
        check("pout", pout_high, 1'b1);
        tick(200);
        check("forced stays", pa_on, 1'b1);
        fork
            txseq_host_model_i.send_frame(24'h1caaaa);
            begin
                tick(20);
                for (int n = 0; n < 150; n++) begin
                    blocked_ok &= (mod_data === 1'b0);
                    tick(1);
                end
            end
        join
        check("mod blocked", blocked_ok, 1'b1);
        tick(5);
        check("ramp down", pa_on, 1'b0);
        repeat (3000) if (synth_relock !== 1'b1) tick(1);
        check("relock", synth_relock, 1'b1);
        repeat (3000) if (pa_on !== 1'b1) tick(1);
        check("ramp up", pa_on, 1'b1);
        check("relock off", synth_relock, 1'b0);
        check("hop carrier", carrier_hz, scaled(19'h4aaaa, 26000000, 1'b1));
        $display("hop done");
        reg_write(REG_XTAL, 32'd24000000);
        reg_read(REG_XTAL);
        check("xtal", rd, 32'd24000000);
        tick(3);
        check("xtal carrier", carrier_hz, scaled(19'h4aaaa, 24000000, 1'b1));
        reg_read(5'h1c);
        check("unmapped", rd, 32'h0);
        // next frame only after the hop has settled
        txseq_host_model_i.send_frame(24'h0020d8);
        tick(10);
        check("forced off", awake, 1'b0);
        txseq_host_model_i.drive(1'b0, 1'b1);
        tick(60);
        txseq_host_model_i.drive(1'b0, 1'b0);
        tick(60);
        check("long idle", awake, 1'b1);
        tick(60);
        check("long sleep", awake, 1'b0);
        $display("forced and idle select done");
        end_of_test;
    end
endmodule
